// ==== rtl/io_diag_params.svh ====
// constants for the discrete I/O fault diagnostics block
// assumes a single 125 MHz system clock
`ifndef IO_DIAG_PARAMS_SVH
`define IO_DIAG_PARAMS_SVH

// clock rate and lamp flash half period
`define DIAG_CLK_KHZ        125000
`define DIAG_FLASH_HALF_MS  200
`define DIAG_FLASH_CYCLES   (`DIAG_FLASH_HALF_MS * `DIAG_CLK_KHZ)

// preactuator valid-operation thresholds, millivolts
`define DIAG_THR24_MV       16'h4650
`define DIAG_THR48_MV       16'h8ca0

// channel grouping
`define DIAG_GRP_CH         8
`define DIAG_MON_CH         16

// module status word fields
`define DIAG_ST_EXT_VOLT    0
`define DIAG_ST_TERM_BLOCK  1
`define DIAG_ST_TRIP        2
`define DIAG_ST_CH_FAULT    3
`define DIAG_ST_INTERNAL    4
`define DIAG_ST_COMM        5
`define DIAG_ST_W           8
`define DIAG_ST_RESET       8'h00

`endif

// ==== rtl/io_diag_pkg.sv ====
// types for the discrete I/O fault diagnostics block
// assumes nothing beyond the params header
package io_diag_pkg;

  // kind of channels the module carries
  typedef enum logic [1:0] {
    KIND_INPUT      = 2'b00,
    KIND_TRANSISTOR = 2'b01,
    KIND_RELAY      = 2'b10
  } io_kind_t;

endpackage : io_diag_pkg

// ==== rtl/io_diag.sv ====
// fault detection and lamp drive of a discrete I/O module
// assumes supply comparators, short sensors, fuse and terminal block
// sense arrive as asynchronous pins; bus-side inputs share CLK_SYS_I
//
// Behaviour
// [RQ1] bus dialog fault flashes the error lamp and sets module fault bit
// [RQ2] internal fault lights error lamp steadily and turns running lamp off
// [RQ3] low sensor or preactuator supply lights I/O lamp, raises voltage flag
// [RQ4] terminal block: one monitor; connector: one monitor per 16 channels
// [RQ5] supply fault puts every channel of that monitor's scope in fault
// [RQ6] missing terminal block flashes I/O lamp and raises block fault
// [RQ7] connector variants sense no connector; supply monitor covers it
// [RQ8] short or overload trips the output, flashes its lamp, lights I/O
// [RQ9] short flag per tripped channel, trip flag per channel group
// [RQ10] tripped channel sets its fault bit and a module status bit
// [RQ11] low sensor supply on inputs sets channel and module fault bits
// [RQ12] preactuator valid only above 18 V on 24 V, 36 V on 48 V rails
// [RQ13] low preactuator supply forces outputs to 0 and sets fault bits
// [RQ14] blown fuse lights I/O lamp and sets that channel's fault bit
// [RQ15] relay and triac variants never raise the output voltage fault
// [RQ16] re-enabling after a trip is done per group of 8 channels
// [RQ17] flashing shares one divided rate; flags hold while cause persists
// [RQ18] a steady lamp request overrides a flashing one
`include "io_diag_params.svh"

module io_diag #(
  parameter int                  NUM_CH     = 32,
  parameter bit                  CONNECTOR  = 1'b1,
  parameter bit                  FUSED      = 1'b0,
  parameter io_diag_pkg::io_kind_t KIND     = io_diag_pkg::KIND_TRANSISTOR,
  parameter int                  FLASH_CYC  = `DIAG_FLASH_CYCLES,
  parameter int                  NGRP       = NUM_CH / `DIAG_GRP_CH,
  parameter int                  NMON       = CONNECTOR ?
                                              NUM_CH / `DIAG_MON_CH : 1
) (
  // clock and reset
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_B_I,
  // bus side, same clock
  input  wire logic              COMM_FAULT_I,
  input  wire logic              INT_FAULT_I,
  input  wire logic              RAIL48_I,
  input  wire logic [NUM_CH-1:0] OUT_CMD_I,
  input  wire logic [NGRP-1:0]   REARM_I,
  // pins, asynchronous
  input  wire logic [NMON-1:0]   SUPPLY_ABOVE_I,
  input  wire logic              TB_PRESENT_I,
  input  wire logic [NUM_CH-1:0] SHORT_I,
  input  wire logic [NUM_CH-1:0] FUSE_BLOWN_I,
  // outputs and comparator threshold
  output logic      [NUM_CH-1:0] OUT_O,
  output logic      [15:0]       THRESH_MV_O,
  // lamps
  output logic                   LED_ERR_O,
  output logic                   LED_RUN_O,
  output logic                   LED_IO_O,
  output logic      [NUM_CH-1:0] LED_CH_O,
  // fault flags and status words
  output logic                   MOD_FAULT_O,
  output logic                   EXT_VOLT_FLT_O,
  output logic                   TB_FLT_O,
  output logic      [NUM_CH-1:0] SHORT_FLT_O,
  output logic      [NGRP-1:0]   TRIP_O,
  output logic      [NUM_CH-1:0] CH_FAULT_O,
  output logic [`DIAG_ST_W-1:0]  MOD_STATUS_O
);

  localparam int PW = NMON + 1 + 2 * NUM_CH;
  localparam bit MONITORED = (KIND != io_diag_pkg::KIND_RELAY);

  // monitor that supplies a channel
  function automatic int mon_of(input int ch);
    mon_of = CONNECTOR ? ch / `DIAG_MON_CH : 0;
  endfunction : mon_of

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [PW-1:0] pin_m_q;
  logic [PW-1:0] pin_s_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= {SUPPLY_ABOVE_I, TB_PRESENT_I, SHORT_I, FUSE_BLOWN_I};
      pin_s_q <= pin_m_q;
    end
  end

  logic [NMON-1:0]   sup_ok_s;
  logic              tb_in_s;
  logic [NUM_CH-1:0] short_s;
  logic [NUM_CH-1:0] fuse_s;
  assign {sup_ok_s, tb_in_s, short_s, fuse_s} = pin_s_q;

  //////////////////////////////////////////////////////////////////////////
  // common flash rate
  logic [31:0] flash_cnt_q;
  logic        flash_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      flash_cnt_q <= 32'h0;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q == 32'(FLASH_CYC - 1)) begin
      flash_cnt_q <= 32'h0; // RQ17
      flash_q     <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // fault derivation
  logic [NMON-1:0]   mon_bad;
  logic [NUM_CH-1:0] ch_sup_bad;
  logic [NUM_CH-1:0] fuse_bad;
  logic [NUM_CH-1:0] tripped_q;
  logic [NUM_CH-1:0] tripped_d;
  logic [NUM_CH-1:0] rearm_ch;
  logic [NGRP-1:0]   grp_trip;
  logic              ext_flt;
  logic              tb_flt;
  logic              io_steady;

  // supply pins of unmonitored variants are ignored
  assign mon_bad  = MONITORED ? ~sup_ok_s : '0; // RQ15
  assign ext_flt  = |mon_bad; // RQ3
  assign tb_flt   = !CONNECTOR && !tb_in_s; // RQ6 RQ7
  assign fuse_bad = FUSED ? fuse_s : '0; // RQ14

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign ch_sup_bad[c] = mon_bad[mon_of(c)]; // RQ4 RQ5
    assign rearm_ch[c]   = REARM_I[c / `DIAG_GRP_CH]; // RQ16
  end

  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    assign grp_trip[g] =
      |tripped_q[g*`DIAG_GRP_CH +: `DIAG_GRP_CH]; // RQ9
  end

  // a short in the rearm cycle keeps the channel tripped
  assign tripped_d = (KIND == io_diag_pkg::KIND_TRANSISTOR) ?
                     ((tripped_q & ~rearm_ch) | short_s) : '0; // RQ8 RQ16

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      tripped_q <= '0;
    end else begin
      tripped_q <= tripped_d;
    end
  end

  assign io_steady = ext_flt || (|tripped_q) || (|fuse_bad);

  //////////////////////////////////////////////////////////////////////////
  // output drive and threshold select
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      OUT_O       <= '0;
      THRESH_MV_O <= `DIAG_THR24_MV;
    end else begin
      OUT_O       <= (KIND == io_diag_pkg::KIND_INPUT) ? '0 :
                     OUT_CMD_I & ~tripped_q & ~ch_sup_bad; // RQ8 RQ13
      THRESH_MV_O <= RAIL48_I ? `DIAG_THR48_MV : `DIAG_THR24_MV; // RQ12
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // lamps
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      LED_ERR_O <= 1'b0;
      LED_RUN_O <= 1'b0;
      LED_IO_O  <= 1'b0;
      LED_CH_O  <= '0;
    end else begin
      LED_ERR_O <= INT_FAULT_I || (COMM_FAULT_I && flash_q); // RQ1 RQ2 RQ18
      LED_RUN_O <= !INT_FAULT_I; // RQ2
      LED_IO_O  <= io_steady || (tb_flt && flash_q); // RQ3 RQ6 RQ18
      LED_CH_O  <= (tripped_q & {NUM_CH{flash_q}}) |
                   (~tripped_q & OUT_CMD_I & ~ch_sup_bad); // RQ8
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flags and status words
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      MOD_FAULT_O    <= 1'b0;
      EXT_VOLT_FLT_O <= 1'b0;
      TB_FLT_O       <= 1'b0;
      SHORT_FLT_O    <= '0;
      TRIP_O         <= '0;
      CH_FAULT_O     <= '0;
      MOD_STATUS_O   <= `DIAG_ST_RESET;
    end else begin
      MOD_FAULT_O    <= COMM_FAULT_I || INT_FAULT_I; // RQ1
      EXT_VOLT_FLT_O <= ext_flt; // RQ3 RQ17
      TB_FLT_O       <= tb_flt; // RQ6
      SHORT_FLT_O    <= tripped_q; // RQ9
      TRIP_O         <= grp_trip; // RQ9
      CH_FAULT_O     <= tripped_q | ch_sup_bad | fuse_bad; // RQ10 RQ11 RQ13
      MOD_STATUS_O   <= '0;
      MOD_STATUS_O[`DIAG_ST_EXT_VOLT]   <= ext_flt; // RQ11 RQ13
      MOD_STATUS_O[`DIAG_ST_TERM_BLOCK] <= tb_flt;
      MOD_STATUS_O[`DIAG_ST_TRIP]       <= |tripped_q;
      MOD_STATUS_O[`DIAG_ST_CH_FAULT]   <=
        |(tripped_q | ch_sup_bad | fuse_bad); // RQ10
      MOD_STATUS_O[`DIAG_ST_INTERNAL]   <= INT_FAULT_I;
      MOD_STATUS_O[`DIAG_ST_COMM]       <= COMM_FAULT_I;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);

  sequence short_seen;
    short_s[0] ##1 tripped_q[0];
  endsequence

  sequence flagged;
    SHORT_FLT_O[0] && TRIP_O[0] && CH_FAULT_O[0];
  endsequence

  chk_comm_fault_bit: assert property ( // RQ1
    COMM_FAULT_I |=> MOD_FAULT_O && MOD_STATUS_O[`DIAG_ST_COMM])
    else $error("dialog fault did not set module fault");

  chk_err_steady_run: assert property ( // RQ2
    INT_FAULT_I |=> LED_ERR_O && !LED_RUN_O)
    else $error("internal fault lamps wrong");

  chk_ext_volt_flag: assert property ( // RQ3
    ext_flt |=> EXT_VOLT_FLT_O && LED_IO_O && CH_FAULT_O != '0)
    else $error("supply fault not indicated");

  chk_outputs_forced: assert property ( // RQ13
    ch_sup_bad != '0 |=> (OUT_O & $past(ch_sup_bad)) == '0)
    else $error("output driven during supply fault");

  chk_short_trip_flags: assert property ( // RQ9
    ((KIND == io_diag_pkg::KIND_TRANSISTOR) and short_seen) |=> flagged)
    else $error("trip flags missing after short");

  chk_trip_held: assert property ( // RQ16
    tripped_q[0] && !REARM_I[0] |=> tripped_q[0] && !OUT_O[0])
    else $error("trip released without group rearm");

  chk_flash_toggle: assert property ( // RQ17
    flash_cnt_q == 32'(FLASH_CYC - 1) |=> $changed(flash_q)
      && flash_cnt_q == 32'h0)
    else $error("flash rate broken");

  chk_tb_flash_lamp: assert property ( // RQ6
    tb_flt && !io_steady |=> LED_IO_O == $past(flash_q) && TB_FLT_O)
    else $error("terminal block lamp not flashing");

  chk_steady_wins: assert property ( // RQ18
    io_steady |=> LED_IO_O)
    else $error("flash overrode steady lamp");

  chk_relay_no_volt: assert property ( // RQ15
    (KIND == io_diag_pkg::KIND_RELAY) |-> !ext_flt ##1 !EXT_VOLT_FLT_O)
    else $error("relay variant raised voltage fault");

endmodule : io_diag

// ==== bench/proc_model.sv ====
// processor-side model driving the bus-side commands of the block
// assumes the block samples them on each rising edge of clk_i
module proc_model #(
  parameter int NUM_CH = 32,
  parameter int NGRP   = 4
) (
  // clock
  input  wire logic              clk_i,
  // bus-side commands
  output logic                   comm_fault_o,
  output logic                   int_fault_o,
  output logic                   rail48_o,
  output logic      [NUM_CH-1:0] out_cmd_o,
  output logic      [NGRP-1:0]   rearm_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    comm_fault_o = 1'b0;
    int_fault_o  = 1'b0;
    rail48_o     = 1'b0;
    out_cmd_o    = '1;
    rearm_o      = '0;
  end

  // one new command set per rising edge, held until the next call
  task automatic drive(input logic c, input logic f, input logic r,
                       input logic [NGRP-1:0] g);
    @(posedge clk_i);
    comm_fault_o <= c;
    int_fault_o  <= f;
    rail48_o     <= r;
    rearm_o      <= g;
  endtask : drive
endmodule : proc_model

// ==== bench/tb_top.sv ====
// self-checking bench of the I/O fault diagnostics block
// assumes a 32-channel connector variant with transistor outputs and
// a 16-channel fused relay variant on a terminal block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        comm, intf, r48;
  logic [31:0] cmd, out, led_ch, sflt, chf;
  logic [3:0]  rearm, trip;
  logic [1:0]  sup = 2'b11;
  logic [31:0] shrt = '0;
  logic [15:0] thr;
  logic        l_err, l_run, l_io, mflt, evf, tbf, a;
  logic [7:0]  st;
  logic        tbp = 1'b1;
  logic        sup2 = 1'b1;
  logic [15:0] fuse = '0;
  logic [15:0] out2, chf2;
  logic        l_io2, evf2, tbf2;
  logic [7:0]  st2;
  int          failures = 0;
  int          checked = 0;

  always #4 clk = ~clk;

  proc_model i_proc (.clk_i(clk), .comm_fault_o(comm), .int_fault_o(intf),
    .rail48_o(r48), .out_cmd_o(cmd), .rearm_o(rearm));

  io_diag #(.FLASH_CYC(4)) i_dut (.CLK_SYS_I(clk), .RST_B_I(rst_b),
    .COMM_FAULT_I(comm), .INT_FAULT_I(intf), .RAIL48_I(r48),
    .OUT_CMD_I(cmd), .REARM_I(rearm), .SUPPLY_ABOVE_I(sup),
    .TB_PRESENT_I(tbp), .SHORT_I(shrt), .FUSE_BLOWN_I({16'h0, fuse}),
    .OUT_O(out), .THRESH_MV_O(thr), .LED_ERR_O(l_err), .LED_RUN_O(l_run),
    .LED_IO_O(l_io), .LED_CH_O(led_ch), .MOD_FAULT_O(mflt),
    .EXT_VOLT_FLT_O(evf), .TB_FLT_O(tbf), .SHORT_FLT_O(sflt),
    .TRIP_O(trip), .CH_FAULT_O(chf), .MOD_STATUS_O(st));

  io_diag #(.NUM_CH(16), .CONNECTOR(1'b0), .FUSED(1'b1),
    .KIND(io_diag_pkg::KIND_RELAY), .FLASH_CYC(4)) i_dut_blk (
    .CLK_SYS_I(clk), .RST_B_I(rst_b), .COMM_FAULT_I(comm),
    .INT_FAULT_I(intf), .RAIL48_I(r48), .OUT_CMD_I(cmd[15:0]),
    .REARM_I(rearm[1:0]), .SUPPLY_ABOVE_I(sup2), .TB_PRESENT_I(tbp),
    .SHORT_I(16'h0), .FUSE_BLOWN_I(fuse), .OUT_O(out2),
    .THRESH_MV_O(), .LED_ERR_O(), .LED_RUN_O(), .LED_IO_O(l_io2),
    .LED_CH_O(), .MOD_FAULT_O(), .EXT_VOLT_FLT_O(evf2), .TB_FLT_O(tbf2),
    .SHORT_FLT_O(), .TRIP_O(), .CH_FAULT_O(chf2), .MOD_STATUS_O(st2));

  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk1(input logic got, input logic exp, input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk1

  task automatic chkv(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chkv

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////
  task automatic t_bus;
    i_proc.drive(1'b1, 1'b0, 1'b0, 4'h0);
    tick(2);
    chk1(mflt, 1'b1, "module fault");
    chk1(st[5], 1'b1, "status comm");
    a = l_err;
    tick(4);
    chk1(l_err, ~a, "err lamp flash");
    i_proc.drive(1'b1, 1'b1, 1'b0, 4'h0);
    tick(2);
    chk1(l_run, 1'b0, "run lamp");
    chk1(l_err, 1'b1, "err steady");
    tick(4);
    chk1(l_err, 1'b1, "err steady");
    i_proc.drive(1'b0, 1'b0, 1'b1, 4'h0);
    tick(2);
    chkv(32'(thr), 32'h8ca0, "48 V threshold");
    chk1(l_run, 1'b1, "run lamp back");
    $display("t_bus done");
  endtask : t_bus

  task automatic t_supply;
    @(posedge clk) sup <= 2'b01;
    tick(5);
    chk1(evf, 1'b1, "ext volt flag");
    chk1(l_io, 1'b1, "io lamp");
    chk1(st[0], 1'b1, "status volt");
    chkv(out, 32'h0000ffff, "outputs forced");
    chkv(chf, 32'hffff0000, "group fault");
    @(posedge clk) sup <= 2'b11;
    tick(5);
    chk1(evf, 1'b0, "flag follows");
    chkv(out, 32'hffffffff, "outputs back");
    $display("t_supply done");
  endtask : t_supply

  task automatic t_short;
    @(posedge clk) shrt <= 32'h201;
    tick(5);
    chkv(sflt, 32'h201, "short flag");
    chkv(32'(trip), 32'h3, "trip group");
    chkv(out, 32'hfffffdfe, "output trip");
    chkv(chf, 32'h201, "channel fault");
    chk1(st[2], 1'b1, "status trip");
    chk1(l_io, 1'b1, "io lamp");
    a = led_ch[9];
    tick(4);
    chk1(led_ch[9], ~a, "channel flash");
    @(posedge clk) shrt <= '0;
    tick(4);
    chkv(sflt, 32'h201, "trip held");
    i_proc.drive(1'b0, 1'b0, 1'b1, 4'h1);
    i_proc.drive(1'b0, 1'b0, 1'b1, 4'h0);
    tick(2);
    chkv(sflt, 32'h200, "other group rearm");
    i_proc.drive(1'b0, 1'b0, 1'b1, 4'h2);
    i_proc.drive(1'b0, 1'b0, 1'b1, 4'h0);
    tick(2);
    chkv(32'(trip), 32'h0, "group rearm");
    chkv(out, 32'hffffffff, "output back");
    $display("t_short done");
  endtask : t_short

  task automatic t_block;
    @(posedge clk) tbp <= 1'b0;
    tick(5);
    chk1(tbf2, 1'b1, "block flag");
    chk1(st2[1], 1'b1, "status block");
    chk1(tbf, 1'b0, "connector ignores block");
    a = l_io2;
    tick(4);
    chk1(l_io2, ~a, "io lamp flash");
    @(posedge clk) fuse <= 16'h10;
    tick(5);
    chkv(32'(chf2), 32'h10, "fuse channel");
    chkv(chf, 32'h0, "unfused ignores fuse");
    chk1(l_io2, 1'b1, "io lamp steady");
    tick(4);
    chk1(l_io2, 1'b1, "io lamp steady");
    @(posedge clk) begin
      tbp  <= 1'b1;
      fuse <= '0;
      sup2 <= 1'b0;
    end
    tick(5);
    chk1(evf2, 1'b0, "relay no volt fault");
    chkv(32'(out2), 32'hffff, "relay outputs kept");
    chkv(32'(chf2), 32'h0, "relay channels ok");
    chk1(tbf2, 1'b0, "block back");
    @(posedge clk) sup2 <= 1'b1;
    $display("t_block done");
  endtask : t_block

  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(3);
    chkv(32'(thr), 32'h4650, "24 V threshold");
    chkv(out, 32'h0, "reset outputs");
    tick(1);
    @(posedge clk) rst_b <= 1'b1;
    tick(6);
    chk1(evf, 1'b0, "supply ok");
    t_bus();
    t_supply();
    t_short();
    t_block();
    close_out();
  end

  // bound on the whole run
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    $display("CHECK FAILED t=%0t run timed out", $time);
    close_out();
  end
endmodule : tb_top
